// *** rtl/hvp_cfg.svh ***
`ifndef HVP_CFG_SVH
`define HVP_CFG_SVH
// core clock rate and pattern latch time, less the sync and edge lag
`define HVP_CLK_MHZ 100
`define HVP_LATCH_US 10
`define HVP_LATCH_CYC (`HVP_LATCH_US * `HVP_CLK_MHZ - 4)
// page geometry, larger variant: 128-word flash pages, 8-byte eeprom pages
`define HVP_FWORD_BITS 7
`define HVP_EBYTE_BITS 3
`define HVP_FPAGE_WORDS 128
`define HVP_EPAGE_BYTES 8
// fuse and lock reset values, a 0 bit means programmed
`define HVP_FUSE_LO_RST 8'h62
`define HVP_FUSE_HI_RST 8'h99
`define HVP_FUSE_EXT_RST 8'hff
`define HVP_LOCK_RST 8'hff
`define HVP_KEEP_EE_BIT 3
// array job queue: kind[33:32], address[31:16], data[15:0]
`define HVP_FIFO_WIDTH 34
`define HVP_FIFO_DEPTH 16
`define HVP_JOB_KIND_LSB 32
`define HVP_JOB_ADDR_LSB 16
// input synchroniser vector width
`define HVP_SYNC_BITS 17
`endif

// *** rtl/hvp_pkg.sv ***
package hvp_pkg;
  // command byte codes
  typedef enum logic [7:0] {
    HVP_CMD_NOP = 8'h00,
    HVP_CMD_ERASE = 8'h80,
    HVP_CMD_WFUSE = 8'h40,
    HVP_CMD_WLOCK = 8'h20,
    HVP_CMD_WFLASH = 8'h10,
    HVP_CMD_WEE = 8'h11,
    HVP_CMD_RSIG = 8'h08,
    HVP_CMD_RFUSE = 8'h04,
    HVP_CMD_RFLASH = 8'h02,
    HVP_CMD_REE = 8'h03
  } hvp_cmd_t;
  // strobe action codes on the two action pins
  typedef enum logic [1:0] {
    HVP_ACT_ADDR = 2'h0,
    HVP_ACT_DATA = 2'h1,
    HVP_ACT_CMD = 2'h2,
    HVP_ACT_IDLE = 2'h3
  } hvp_act_t;
  // job kinds passed to the array controller
  typedef enum logic [1:0] {
    HVP_JOB_FLASH = 2'h0,
    HVP_JOB_EE = 2'h1,
    HVP_JOB_ERASE_FLASH = 2'h2,
    HVP_JOB_ERASE_EE = 2'h3
  } hvp_job_t;
  // operation sequencer, one-hot
  typedef enum logic [5:0] {
    HVP_ST_IDLE = 6'h01,
    HVP_ST_FILL = 6'h02,
    HVP_ST_ERASE_F = 6'h04,
    HVP_ST_WAIT_F = 6'h08,
    HVP_ST_ERASE_E = 6'h10,
    HVP_ST_DRAIN = 6'h20
  } hvp_state_t;
endpackage : hvp_pkg

// *** rtl/hvp_sync.sv ***
`timescale 1ns/100ps
module hvp_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1;

  // two flops per bit; stage1 feeds nothing but syncOut
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      stage1 <= '0;
      syncOut <= '0;
    end else begin
      stage1 <= asyncIn;
      syncOut <= stage1;
    end
  end
endmodule : hvp_sync

// *** rtl/hvp_fifo.sv ***
`timescale 1ns/100ps
module hvp_fifo #(
  parameter int WIDTH = 34,
  parameter int DEPTH = 16
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr;
  logic [PW-1:0] rdPtr;
  logic [PW:0] count;
  logic push;
  logic pop;

  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  // honest flags straight from the occupancy count
  assign inReady = (count != (PW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData = mem[rdPtr];

  // storage, written only on an accepted word
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

  // pointers and occupancy
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (push) wrPtr <= wrPtr + 1'b1;
      if (pop) rdPtr <= rdPtr + 1'b1;
      if (push && !pop) count <= count + 1'b1;
      else if (pop && !push) count <= count - 1'b1;
    end
  end
endmodule : hvp_fifo

// *** rtl/hvp_port.sv ***
// Notes on behaviour
// - progressFlag low while erase or page programming runs, high when ready.
// - data bus driven only while readDrive_n is low, otherwise an input.
// - byteSelLoHi 0 picks low byte, 1 picks high byte.
// - byteSelExt 1 picks the second high byte, extending byteSelLoHi.
// - entry pattern must be 0000, held 10 us after high voltage; latched.
// - mode ends when high voltage on the reset pin drops or on power-down.
// - load strobe action 00 address, 01 data, 10 command, 11 nothing.
// - address load stores low or high address byte per byteSelLoHi.
// - write commands: erase, fuses, locks, flash, eeprom are decoded.
// - read commands: signature, fuse and lock, flash, eeprom are decoded.
// - loaded command and address are kept across operations.
// - flash pages of 128 words; low seven address bits pick the word.
// - eeprom pages of 8 bytes; low three address bits pick the byte.
// - chip erase clears flash, eeprom, locks; locks freed after flash erase.
// - programmed keep-eeprom fuse skips the eeprom erase.
// - write strobe after erase command starts erase, progressFlag goes low.
// - data load captures low or high data byte per byteSelLoHi.
// - buffer latch pulse writes loaded data into page buffer word.
// - upper bits of address low byte serve as page index bits.
// - write strobe with flash command programs whole page buffer.
// - command 00 is a no-op and ends the page session.
// - fuses latched at mode entry; keep-eeprom fuse acts at once.
`timescale 1ns/100ps
`include "hvp_cfg.svh"
module hvp_port import hvp_pkg::*; #(
  parameter logic [7:0] SIG_BYTE0 = 8'h5a, // arbitrary identity value
  parameter logic [7:0] SIG_BYTE1 = 8'h01, // arbitrary identity value
  parameter logic [7:0] SIG_BYTE2 = 8'h02, // arbitrary identity value
  parameter logic [7:0] CAL_BYTE = 8'h80
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic hvPresent,
  input wire logic loadStrobe,
  input wire logic bufferLatchPulse,
  input wire logic programStrobe_n,
  input wire logic readDrive_n,
  input wire logic strobeActionMsb,
  input wire logic strobeActionLsb,
  input wire logic byteSelLoHi,
  input wire logic byteSelExt,
  input wire logic [7:0] dataIn,
  output logic [7:0] dataOut,
  output logic dataOe,
  output logic progressFlag,
  output logic modeActive,
  output logic [7:0] activeFuseLo,
  output logic [7:0] activeFuseHi,
  output logic [7:0] activeFuseExt,
  output logic [7:0] lockState,
  output logic [15:0] readAddr,
  input wire logic [15:0] flashRdData,
  input wire logic [7:0] eeRdData,
  output logic jobValid,
  input wire logic jobReady,
  output logic [1:0] jobKind,
  output logic [15:0] jobAddr,
  output logic [15:0] jobData,
  input wire logic arrayIdle
);
  logic [`HVP_SYNC_BITS-1:0] syncVec;
  logic hvS, loadS, latchS, progS_n, readS_n, actMsbS, actLsbS, bsLoS, bsExtS;
  logic [7:0] busS;
  logic loadPrev, latchPrev, progPrev;
  logic loadRise, latchRise, progFall;
  logic hvPrev;
  logic [10:0] entryCnt;
  logic entryTiming;
  hvp_cmd_t cmd;
  logic [7:0] addrLo, addrHi, dataLo, dataHi;
  logic [15:0] flashBuf [`HVP_FPAGE_WORDS];
  logic [7:0] eeBuf [`HVP_EPAGE_BYTES];
  logic [7:0] fuseLo, fuseHi, fuseExt;
  hvp_state_t state, next_state;
  logic [6:0] fillIdx;
  logic isEeFill;
  logic fillLast;
  logic jobPush, jobInReady;
  logic [`HVP_FIFO_WIDTH-1:0] jobWord;
  logic [`HVP_FIFO_WIDTH-1:0] jobOut;
  logic jobTaken;
  logic arrayDone;
  logic keepEe;
  logic [7:0] next_dataOut;

  // every pin passes two flops before logic looks at it
  hvp_sync #(.WIDTH(`HVP_SYNC_BITS)) u_sync (
    .core_clk(core_clk),
    .reset(reset),
    .asyncIn({hvPresent, loadStrobe, bufferLatchPulse, programStrobe_n, readDrive_n,
      strobeActionMsb, strobeActionLsb, byteSelLoHi, byteSelExt, dataIn}),
    .syncOut(syncVec)
  );
  assign {hvS, loadS, latchS, progS_n, readS_n, actMsbS, actLsbS, bsLoS, bsExtS, busS} =
    syncVec;

  // edge detection on synchronised strobes
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      loadPrev <= 1'b0;
      latchPrev <= 1'b0;
      progPrev <= 1'b1;
      hvPrev <= 1'b0;
    end else begin
      loadPrev <= loadS;
      latchPrev <= latchS;
      progPrev <= progS_n;
      hvPrev <= hvS;
    end
  end
  assign loadRise = modeActive && loadS && !loadPrev;
  assign latchRise = modeActive && latchS && !latchPrev;
  assign progFall = modeActive && progPrev && !progS_n;

  // mode entry and exit
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      entryCnt <= '0;
      entryTiming <= 1'b0;
      modeActive <= 1'b0;
    end else if (!hvS) begin
      entryCnt <= '0;
      entryTiming <= 1'b0;
      modeActive <= 1'b0;
    end else if (hvS && !hvPrev) begin
      entryTiming <= 1'b1;
      entryCnt <= '0;
    end else if (entryTiming) begin
      entryCnt <= entryCnt + 1'b1;
      // pattern latched inside the hold time
      if (entryCnt == 11'(`HVP_LATCH_CYC - 1)) begin
        entryTiming <= 1'b0;
        modeActive <= ({latchS, actMsbS, actLsbS, bsLoS} == 4'h0);
      end
    end
  end

  // fuses latched at entry; changes show only after the next entry
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      activeFuseLo <= `HVP_FUSE_LO_RST;
      activeFuseHi <= `HVP_FUSE_HI_RST;
      activeFuseExt <= `HVP_FUSE_EXT_RST;
    end else if (entryTiming && entryCnt == 11'(`HVP_LATCH_CYC - 1)) begin
      activeFuseLo <= fuseLo;
      activeFuseHi <= fuseHi;
      activeFuseExt <= fuseExt;
    end
  end
  // the keep-eeprom fuse acts at once, so the live value is used
  assign keepEe = !fuseHi[`HVP_KEEP_EE_BIT];

  // command, address and data loading on the load strobe
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cmd <= HVP_CMD_NOP;
      addrLo <= '0;
      addrHi <= '0;
      dataLo <= '0;
      dataHi <= '0;
    end else if (loadRise) begin
      // action decode, values held until reloaded
      unique case (hvp_act_t'({actMsbS, actLsbS}))
        HVP_ACT_ADDR: begin
          if (bsLoS) addrHi <= busS;
          else addrLo <= busS;
        end
        HVP_ACT_DATA: begin
          if (bsLoS) dataHi <= busS;
          else dataLo <= busS;
        end
        HVP_ACT_CMD: begin
          // unknown codes fall back to no-op, ends the session
          unique case (busS)
            HVP_CMD_ERASE, HVP_CMD_WFUSE, HVP_CMD_WLOCK, HVP_CMD_WFLASH, HVP_CMD_WEE,
            HVP_CMD_RSIG, HVP_CMD_RFUSE, HVP_CMD_RFLASH, HVP_CMD_REE: cmd <= hvp_cmd_t'(busS);
            default: cmd <= HVP_CMD_NOP;
          endcase
        end
        HVP_ACT_IDLE: begin
        end
      endcase
    end
  end

  // page buffers; no reset, contents are don't-care until latched
  always_ff @(posedge core_clk) begin
    // latch pulse stores the loaded word at the low address bits
    if (latchRise && cmd == HVP_CMD_WFLASH) begin
      flashBuf[addrLo[`HVP_FWORD_BITS-1:0]] <= {dataHi, dataLo};
    end
    if (latchRise && cmd == HVP_CMD_WEE) begin
      eeBuf[addrLo[`HVP_EBYTE_BITS-1:0]] <= dataLo;
    end
  end

  // fuse and lock storage
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      fuseLo <= `HVP_FUSE_LO_RST;
      fuseHi <= `HVP_FUSE_HI_RST;
      fuseExt <= `HVP_FUSE_EXT_RST;
      lockState <= `HVP_LOCK_RST;
    end else if (state == HVP_ST_WAIT_F && arrayDone) begin
      // locks freed only once flash erase is complete
      lockState <= `HVP_LOCK_RST;
    end else if (progFall && progressFlag) begin
      if (cmd == HVP_CMD_WFUSE) begin
        if (!bsExtS && !bsLoS) fuseLo <= dataLo;
        else if (!bsExtS && bsLoS) fuseHi <= dataLo;
        else if (bsExtS && !bsLoS) fuseExt <= dataLo;
      end
      // lock bits can only be programmed; erase clears them
      if (cmd == HVP_CMD_WLOCK) lockState <= lockState & dataLo;
    end
  end

  // a job is finished when the queue is empty and the array is idle again;
  // the cycle right after a hand-off is excluded since idle lags by one
  assign arrayDone = !jobValid && arrayIdle && !jobTaken;
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) jobTaken <= 1'b0;
    else jobTaken <= jobValid && jobReady;
  end

  // page fill walker
  assign fillLast = isEeFill ? (fillIdx == 7'(`HVP_EPAGE_BYTES - 1)) :
    (fillIdx == 7'(`HVP_FPAGE_WORDS - 1));
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      fillIdx <= '0;
      isEeFill <= 1'b0;
    end else if (state == HVP_ST_IDLE) begin
      fillIdx <= '0;
      isEeFill <= (cmd == HVP_CMD_WEE);
    end else if (state == HVP_ST_FILL && jobInReady) begin
      fillIdx <= fillIdx + 1'b1;
    end
  end

  // sequencer next state
  always_comb begin
    next_state = state;
    unique case (state)
      HVP_ST_IDLE: begin
        if (progFall && progressFlag) begin
          if (cmd == HVP_CMD_ERASE) next_state = HVP_ST_ERASE_F;
          else if (cmd == HVP_CMD_WFLASH || cmd == HVP_CMD_WEE) next_state = HVP_ST_FILL;
        end
      end
      HVP_ST_FILL: if (jobInReady && fillLast) next_state = HVP_ST_DRAIN;
      HVP_ST_ERASE_F: if (jobInReady) next_state = HVP_ST_WAIT_F;
      HVP_ST_WAIT_F: begin
        // skip eeprom erase when the keep fuse is programmed
        if (arrayDone) next_state = keepEe ? HVP_ST_IDLE : HVP_ST_ERASE_E;
      end
      HVP_ST_ERASE_E: if (jobInReady) next_state = HVP_ST_DRAIN;
      HVP_ST_DRAIN: if (arrayDone) next_state = HVP_ST_IDLE;
    endcase
    if (!modeActive) next_state = HVP_ST_IDLE;
  end

  // state and ready/busy flag
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      state <= HVP_ST_IDLE;
      progressFlag <= 1'b1;
    end else begin
      state <= next_state;
      progressFlag <= (next_state == HVP_ST_IDLE);
    end
  end

  // job words toward the array controller
  always_comb begin
    jobPush = 1'b0;
    jobWord = '0;
    unique case (state)
      HVP_ST_FILL: begin
        jobPush = 1'b1;
        // page index from the upper address bits above the in-page index
        if (isEeFill) begin
          jobWord = {HVP_JOB_EE, addrHi, addrLo[7:`HVP_EBYTE_BITS],
            fillIdx[`HVP_EBYTE_BITS-1:0], 8'h00, eeBuf[fillIdx[`HVP_EBYTE_BITS-1:0]]};
        end else begin
          jobWord = {HVP_JOB_FLASH, addrHi, addrLo[7], fillIdx, flashBuf[fillIdx]};
        end
      end
      HVP_ST_ERASE_F: begin
        // flash first, so locks stay set until it is gone
        jobPush = 1'b1;
        jobWord = {HVP_JOB_ERASE_FLASH, 32'h0000_0000};
      end
      HVP_ST_ERASE_E: begin
        jobPush = 1'b1;
        jobWord = {HVP_JOB_ERASE_EE, 32'h0000_0000};
      end
      default: begin
      end
    endcase
  end

  // the queue stalls the fill walker when the array falls behind
  hvp_fifo #(.WIDTH(`HVP_FIFO_WIDTH), .DEPTH(`HVP_FIFO_DEPTH)) u_jobq (
    .core_clk(core_clk),
    .reset(reset),
    .inValid(jobPush),
    .inReady(jobInReady),
    .inData(jobWord),
    .outValid(jobValid),
    .outReady(jobReady),
    .outData(jobOut)
  );
  assign jobKind = jobOut[`HVP_FIFO_WIDTH-1:`HVP_JOB_KIND_LSB];
  assign jobAddr = jobOut[`HVP_JOB_KIND_LSB-1:`HVP_JOB_ADDR_LSB];
  assign jobData = jobOut[`HVP_JOB_ADDR_LSB-1:0];

  // read data select
  always_comb begin
    next_dataOut = 8'h00;
    unique case (cmd)
      HVP_CMD_RFLASH: next_dataOut = bsLoS ? flashRdData[15:8] : flashRdData[7:0];
      HVP_CMD_REE: next_dataOut = eeRdData;
      HVP_CMD_RFUSE: begin
        // two selects pick among four bytes
        unique case ({bsExtS, bsLoS})
          2'h0: next_dataOut = fuseLo;
          2'h3: next_dataOut = fuseHi;
          2'h2: next_dataOut = fuseExt;
          2'h1: next_dataOut = lockState;
        endcase
      end
      HVP_CMD_RSIG: begin
        if (bsLoS) next_dataOut = CAL_BYTE;
        else if (addrLo[1:0] == 2'h0) next_dataOut = SIG_BYTE0;
        else if (addrLo[1:0] == 2'h1) next_dataOut = SIG_BYTE1;
        else if (addrLo[1:0] == 2'h2) next_dataOut = SIG_BYTE2;
      end
      default: next_dataOut = 8'h00;
    endcase
  end

  // bus drive, registered so the pins never glitch
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      dataOut <= 8'h00;
      dataOe <= 1'b0;
      readAddr <= 16'h0000;
    end else begin
      dataOut <= next_dataOut;
      // drive only in mode and while the read enable is low
      dataOe <= modeActive && !readS_n;
      readAddr <= {addrHi, addrLo};
    end
  end
endmodule : hvp_port

// *** test/hvp_array_model.sv ***
`timescale 1ns/100ps
module hvp_array_model import hvp_pkg::*; (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic jobValid,
  output logic jobReady,
  input wire logic [1:0] jobKind,
  input wire logic [15:0] jobAddr,
  input wire logic [15:0] jobData,
  output logic arrayIdle,
  input wire logic [15:0] readAddr,
  output logic [15:0] flashRdData,
  output logic [7:0] eeRdData
);
  logic [15:0] fm [0:65535];
  logic [7:0] em [0:65535];
  int left;
  // erased cells read as all ones
  initial begin
    for (int i = 0; i < 65536; i++) begin
      fm[i] = 16'hffff;
      em[i] = 8'hff;
    end
  end
  // read path follows the registered address
  assign flashRdData = fm[readAddr];
  assign eeRdData = em[readAddr];
  // one job at a time; ready stalls at random, erase is slow
  always @(posedge core_clk or posedge reset) begin
    if (reset) begin
      jobReady <= 1'b0;
      arrayIdle <= 1'b1;
      left = 0;
    end else if (jobValid && jobReady) begin
      jobReady <= 1'b0;
      arrayIdle <= 1'b0;
      left = jobKind[1] ? 200 : $urandom_range(1, 6);
      case (jobKind)
        HVP_JOB_FLASH: fm[jobAddr] = jobData;
        HVP_JOB_EE: em[jobAddr] = jobData[7:0];
        HVP_JOB_ERASE_FLASH: for (int i = 0; i < 65536; i++) fm[i] = 16'hffff;
        default: for (int i = 0; i < 65536; i++) em[i] = 8'hff;
      endcase
    end else if (left > 0) begin
      left = left - 1;
      arrayIdle <= (left == 0);
    end else begin
      jobReady <= 1'($urandom_range(0, 1));
    end
  end
endmodule : hvp_array_model

// *** test/hvp_port_checker.sv ***
`timescale 1ns/100ps
module hvp_port_checker (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic hvPresent,
  input wire logic readDrive_n,
  input wire logic dataOe,
  input wire logic progressFlag,
  input wire logic modeActive,
  input wire logic jobValid,
  input wire logic jobReady,
  input wire logic [1:0] jobKind,
  input wire logic [15:0] jobAddr,
  input wire logic [15:0] jobData,
  input wire logic arrayIdle
);
  logic [10:0] hvCnt;
  logic [8:0] jobCnt;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // cycles of high voltage, saturating
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) hvCnt <= 11'h0;
    else if (!hvPresent) hvCnt <= 11'h0;
    else if (hvCnt != 11'h7ff) hvCnt <= hvCnt + 11'h1;
  end
  // jobs accepted within one busy spell
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) jobCnt <= 9'h0;
    else if (progressFlag) jobCnt <= 9'h0;
    else jobCnt <= jobCnt + {8'h0, jobValid & jobReady};
  end
  property p_entryTime; $rose(modeActive) |-> hvCnt inside {[11'h3e0:11'h3e7]}; endproperty
  a_entryTime: assert property (p_entryTime) else $error("mode entered early");
  property p_exit; !hvPresent [*6] |-> !modeActive; endproperty
  a_exit: assert property (p_exit) else $error("mode kept without voltage");
  property p_oeOn; $fell(readDrive_n) && modeActive |-> ##[2:5] dataOe; endproperty
  a_oeOn: assert property (p_oeOn) else $error("bus not driven");
  property p_oeOff; $rose(readDrive_n) |-> ##[2:5] !dataOe; endproperty
  a_oeOff: assert property (p_oeOff) else $error("bus not released");
  property p_jobBusy; jobValid |-> !progressFlag; endproperty
  a_jobBusy: assert property (p_jobBusy) else $error("job while ready");
  property p_ready; $rose(progressFlag) |-> !jobValid && $past(arrayIdle); endproperty
  a_ready: assert property (p_ready) else $error("ready before done");
  property p_count; $rose(progressFlag) |-> jobCnt inside {9'h1, 9'h2, 9'h8, 9'h80}; endproperty
  a_count: assert property (p_count) else $error("wrong job count");
  property p_hold;
    jobValid && !jobReady |=> jobValid && $stable({jobKind, jobAddr, jobData});
  endproperty
  a_hold: assert property (p_hold) else $error("job changed while stalled");
  c_page: cover property ($rose(progressFlag) && jobCnt == 9'h80);
  c_read: cover property ($rose(dataOe));
  c_entry: cover property ($rose(modeActive));
endmodule : hvp_port_checker
bind hvp_port hvp_port_checker u_hvp_port_checker (
  .core_clk(core_clk), .reset(reset), .hvPresent(hvPresent), .readDrive_n(readDrive_n),
  .dataOe(dataOe), .progressFlag(progressFlag), .modeActive(modeActive),
  .jobValid(jobValid), .jobReady(jobReady), .jobKind(jobKind), .jobAddr(jobAddr),
  .jobData(jobData), .arrayIdle(arrayIdle)
);

// *** test/testbench.sv ***
`timescale 1ns/100ps
module testbench;
  import hvp_pkg::*;
  localparam logic [7:0] SIG [3] = '{8'h3c, 8'h07, 8'h0b}; // arbitrary identity values
  localparam logic [7:0] CAL = 8'h6d;
  logic core_clk, reset, hvPresent, loadStrobe, bufferLatchPulse, programStrobe_n;
  logic readDrive_n, strobeActionMsb, strobeActionLsb, byteSelLoHi, byteSelExt;
  logic [7:0] dataIn, dataOut, busDrv, activeFuseLo, activeFuseHi, activeFuseExt;
  logic [7:0] lockState, eeRdData, hi, lo;
  logic [15:0] readAddr, flashRdData, jobAddr, jobData;
  logic [1:0] jobKind;
  logic dataOe, progressFlag, modeActive, jobValid, jobReady, arrayIdle;
  logic [15:0] ef [int];
  logic [7:0] ee [int];
  int miscompares, comparisons;
  // shared bus: the port wins while it drives
  assign dataIn = dataOe ? dataOut : busDrv;
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  hvp_port #(.SIG_BYTE0(SIG[0]), .SIG_BYTE1(SIG[1]), .SIG_BYTE2(SIG[2]), .CAL_BYTE(CAL))
  u_hvp_port (
    .core_clk(core_clk), .reset(reset), .hvPresent(hvPresent), .loadStrobe(loadStrobe),
    .bufferLatchPulse(bufferLatchPulse), .programStrobe_n(programStrobe_n),
    .readDrive_n(readDrive_n), .strobeActionMsb(strobeActionMsb),
    .strobeActionLsb(strobeActionLsb), .byteSelLoHi(byteSelLoHi), .byteSelExt(byteSelExt),
    .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .progressFlag(progressFlag),
    .modeActive(modeActive), .activeFuseLo(activeFuseLo), .activeFuseHi(activeFuseHi),
    .activeFuseExt(activeFuseExt), .lockState(lockState), .readAddr(readAddr),
    .flashRdData(flashRdData), .eeRdData(eeRdData), .jobValid(jobValid),
    .jobReady(jobReady), .jobKind(jobKind), .jobAddr(jobAddr), .jobData(jobData),
    .arrayIdle(arrayIdle)
  );
  hvp_array_model u_hvp_array_model (
    .core_clk(core_clk), .reset(reset), .jobValid(jobValid), .jobReady(jobReady),
    .jobKind(jobKind), .jobAddr(jobAddr), .jobData(jobData), .arrayIdle(arrayIdle),
    .readAddr(readAddr), .flashRdData(flashRdData), .eeRdData(eeRdData)
  );
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk
  task automatic wrap_up();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up
  // one load pulse; pins settle well before and after the synced edge
  task automatic ld(input logic [1:0] a, input logic bs, input logic [7:0] d);
    tick(1);
    {strobeActionMsb, strobeActionLsb} <= a;
    byteSelLoHi <= bs;
    busDrv <= d;
    tick(5);
    loadStrobe <= 1'b1;
    tick(6);
    loadStrobe <= 1'b0;
    tick(5);
  endtask : ld
  task automatic latch();
    tick(1);
    bufferLatchPulse <= 1'b1;
    tick(6);
    bufferLatchPulse <= 1'b0;
  endtask : latch
  // write strobe twice, the second lands while busy on erase and page writes (fuse and lock writes never go busy), then bounded wait
  task automatic prog();
    int n;
    for (n = 0; n < 2; n++) begin
      tick(5);
      programStrobe_n <= 1'b0;
      tick(6);
      programStrobe_n <= 1'b1;
    end
    for (n = 0; n < 50000 && progressFlag !== 1'b1; n++) tick(1);
    if (n == 50000) begin
      miscompares++;
      $display("[FAIL] %0t busy timeout", $time);
      wrap_up();
    end
  endtask : prog
  task automatic rd(input logic bs, input logic ex, input logic [7:0] e);
    tick(1);
    byteSelLoHi <= bs;
    byteSelExt <= ex;
    readDrive_n <= 1'b0;
    tick(8);
    chk({7'h0, dataOe, dataOut}, {8'h1, e}, "read byte");
    readDrive_n <= 1'b1;
    tick(8);
  endtask : rd
  task automatic enter(input logic [3:0] pat, input logic exp);
    tick(1);
    {bufferLatchPulse, strobeActionMsb, strobeActionLsb, byteSelLoHi} <= pat;
    hvPresent <= 1'b1;
    tick(1100);
    chk(modeActive, exp, "mode entry");
    hvPresent <= exp;
    tick(10);
  endtask : enter
  task automatic eerd();
    ld(HVP_ACT_CMD, 1'b0, HVP_CMD_REE);
    for (int b8 = 0; b8 < 8; b8++) begin
      ld(HVP_ACT_ADDR, 1'b0, {lo[7:3], b8[2:0]});
      rd(1'b0, 1'b0, ee[{hi, lo[7:3], b8[2:0]}]);
    end
  endtask : eerd
  function automatic logic [15:0] fx(input int a);
    return ef.exists(a) ? ef[a] : 16'hffff;
  endfunction : fx
  // main sequence
  initial begin
    logic [15:0] d;
    logic [7:0] fv [3];
    logic b;
    miscompares = 0;
    comparisons = 0;
    reset = 1'b1;
    {hvPresent, loadStrobe, bufferLatchPulse, strobeActionMsb, strobeActionLsb} = 5'h0;
    {byteSelLoHi, byteSelExt, busDrv} = 10'h0;
    {programStrobe_n, readDrive_n} = 2'h3;
    void'($urandom(32'ha89f));
    tick(20);
    reset <= 1'b0;
    tick(2);
    chk({progressFlag, modeActive, dataOe, jobValid}, 16'h8, "reset flags");
    chk({activeFuseLo, activeFuseHi}, 16'h6299, "reset fuses");
    chk({activeFuseExt, lockState}, 16'hffff, "reset ext lock");
    enter(4'h1, 1'b0);
    enter(4'h0, 1'b1);
    tick(30000);
    $display("test entry done");
    ld(HVP_ACT_CMD, 1'b0, HVP_CMD_WLOCK);
    ld(HVP_ACT_DATA, 1'b0, 8'hfc);
    prog();
    ld(HVP_ACT_CMD, 1'b0, HVP_CMD_RFUSE);
    rd(1'b1, 1'b0, 8'hfc);
    ld(HVP_ACT_CMD, 1'b0, HVP_CMD_ERASE);
    prog();
    chk(lockState, 8'hff, "lock after erase");
    $display("test erase done");
    hi = 8'($urandom);
    lo = 8'($urandom);
    ld(HVP_ACT_CMD, 1'b0, HVP_CMD_WFLASH);
    ld(HVP_ACT_ADDR, 1'b1, hi);
    for (int w = 0; w < 128; w++) begin
      d = 16'($urandom);
      ef[{hi, lo[7], w[6:0]}] = d;
      ld(HVP_ACT_ADDR, 1'b0, {lo[7], w[6:0]});
      ld(HVP_ACT_DATA, 1'b0, d[7:0]);
      ld(HVP_ACT_DATA, 1'b1, d[15:8]);
      latch();
    end
    prog();
    ld(HVP_ACT_CMD, 1'b0, HVP_CMD_RFLASH);
    for (int i = 0; i < 8; i++) begin
      lo = 8'($urandom);
      ld(HVP_ACT_ADDR, 1'b0, lo);
      d = fx({hi, lo});
      rd(1'b0, 1'b0, d[7:0]);
      rd(1'b1, 1'b0, d[15:8]);
    end
    $display("test flash done");
    ld(HVP_ACT_CMD, 1'b0, HVP_CMD_WEE);
    for (int b8 = 0; b8 < 8; b8++) begin
      d = 16'($urandom);
      ee[{hi, lo[7:3], b8[2:0]}] = d[7:0];
      ld(HVP_ACT_ADDR, 1'b0, {lo[7:3], b8[2:0]});
      ld(HVP_ACT_DATA, 1'b0, d[7:0]);
      latch();
    end
    prog();
    eerd();
    fv = '{8'h6f, 8'h91, 8'hfd};
    ld(HVP_ACT_CMD, 1'b0, HVP_CMD_WFUSE);
    for (int k = 0; k < 3; k++) begin
      ld(HVP_ACT_DATA, 1'b0, fv[k]);
      byteSelLoHi <= (k == 1);
      byteSelExt <= (k == 2);
      prog();
    end
    ld(HVP_ACT_CMD, 1'b0, HVP_CMD_RFUSE);
    rd(1'b0, 1'b0, fv[0]);
    rd(1'b1, 1'b1, fv[1]);
    rd(1'b0, 1'b1, fv[2]);
    rd(1'b1, 1'b0, 8'hff);
    chk(activeFuseHi, 8'h99, "fuse latched");
    // eeprom kept by the freshly programmed fuse
    ld(HVP_ACT_CMD, 1'b0, HVP_CMD_ERASE);
    prog();
    eerd();
    ld(HVP_ACT_CMD, 1'b0, HVP_CMD_RFLASH);
    rd(1'b0, 1'b0, 8'hff);
    $display("test fuse done");
    ld(HVP_ACT_CMD, 1'b0, HVP_CMD_WEE);
    ld(HVP_ACT_CMD, 1'b0, HVP_CMD_NOP);
    programStrobe_n <= 1'b0;
    b = 1'b1;
    for (int i = 0; i < 20; i++) begin
      tick(1);
      b &= progressFlag;
    end
    programStrobe_n <= 1'b1;
    chk(b, 1'b1, "nop stays ready");
    ld(HVP_ACT_CMD, 1'b0, HVP_CMD_RSIG);
    for (int i = 0; i < 3; i++) begin
      ld(HVP_ACT_ADDR, 1'b0, i[7:0]);
      ld(HVP_ACT_IDLE, 1'b0, 8'h2 - i[7:0]);
      rd(1'b0, 1'b0, SIG[i]);
    end
    ld(HVP_ACT_ADDR, 1'b0, 8'h0);
    rd(1'b1, 1'b0, CAL);
    $display("test signature done");
    hvPresent <= 1'b0;
    tick(10);
    chk(modeActive, 1'b0, "mode exit");
    enter(4'h0, 1'b1);
    chk({activeFuseLo, activeFuseHi}, 16'h6f91, "fuse relatched");
    chk(activeFuseExt, 8'hfd, "ext relatched");
    $display("test reentry done");
    wrap_up();
  end
endmodule : testbench
